// file: rtl/ulp_element.sv
// unbalanced load protection element, top level
module ulp_element
(
	input  wire logic                      clock,
	input  wire logic                      sys_rst,
	input  wire logic                      prot_reset,
	input  wire logic                      sample_tick,
	input  wire logic [ulp_pkg::CUR_W-1:0] phase_a,
	input  wire logic [ulp_pkg::CUR_W-1:0] phase_b,
	input  wire logic [ulp_pkg::CUR_W-1:0] phase_c,
	input  wire logic                      rotation_reversed,
	input  wire logic [ulp_pkg::CUR_W-1:0] neg_seq_threshold,
	input  wire logic                      use_full_load_threshold,
	input  wire logic [ulp_pkg::CUR_W-1:0] full_load_relative_threshold,
	input  wire logic [ulp_pkg::CUR_W-1:0] full_load_current,
	input  wire logic                      ratio_enable,
	input  wire logic [ulp_pkg::PCT_W-1:0] unbalance_ratio_setting,
	input  wire logic                      thermal_curve,
	input  wire logic [ulp_pkg::TIM_W-1:0] fixed_delay,
	input  wire logic [ulp_pkg::TIM_W-1:0] capability_k,
	input  wire logic [ulp_pkg::CUR_W-1:0] heat_scale,
	input  wire logic [ulp_pkg::SHF_W-1:0] cool_shift,
	output logic                           pickup,
	output logic                           trip,
	output logic      [ulp_pkg::CUR_W-1:0] neg_seq_value,
	output logic      [ulp_pkg::CUR_W-1:0] pos_seq_value
);
	// -----------------------------------------------------------------
	// sequence components
	// -----------------------------------------------------------------
	ulp_seq_if seq ();
	ulp_seq_calc u_seq
	(
		.clock             (clock),
		.sys_rst           (sys_rst),
		.sample_tick       (sample_tick),
		.rotation_reversed (rotation_reversed),
		.phase_a           (phase_a),
		.phase_b           (phase_b),
		.phase_c           (phase_c),
		.seq               (seq)
	);
	assign neg_seq_value = seq.neg_seq;
	assign pos_seq_value = seq.pos_seq;
	// -----------------------------------------------------------------
	// pickup decision
	// -----------------------------------------------------------------
	function automatic logic [ulp_pkg::CUR_W-1:0] pu_mul
	(
		input logic [ulp_pkg::CUR_W-1:0] a,
		input logic [ulp_pkg::CUR_W-1:0] b
	);
		logic [2*ulp_pkg::CUR_W-1:0] p;
		p = (a * b) >> ulp_pkg::CUR_FRAC;
		pu_mul = (p[2*ulp_pkg::CUR_W-1:ulp_pkg::CUR_W] != '0) ? '1 : p[ulp_pkg::CUR_W-1:0];
	endfunction
	logic [ulp_pkg::CUR_W-1:0] thr_pu;
	logic                      above_thr;
	logic [ulp_pkg::CUR_W+6:0] neg_pct;
	logic [ulp_pkg::CUR_W+6:0] pos_pct;
	logic                      ratio_ok;
	logic                      cond;
	// threshold held in per unit of nominal current, so direct compare
	assign thr_pu    = use_full_load_threshold
	                   ? pu_mul(full_load_relative_threshold, full_load_current)
	                   : neg_seq_threshold;
	assign above_thr = seq.neg_seq > thr_pu;
	assign neg_pct   = {7'h00, seq.neg_seq} * ulp_pkg::CUR_W'(ulp_pkg::PCT_FULL);
	assign pos_pct   = {7'h00, seq.pos_seq} * unbalance_ratio_setting;
	assign ratio_ok  = !ratio_enable || (neg_pct > pos_pct);
	assign cond      = above_thr && ratio_ok;
	// -----------------------------------------------------------------
	// thermal model
	// -----------------------------------------------------------------
	// theta_max = K scaled to the same units as the heating increment
	logic [ulp_pkg::TH_W-1:0] theta;
	logic [ulp_pkg::TH_W-1:0] theta_max;
	logic                     theta_over;
	assign theta_max = ulp_pkg::TH_W'(capability_k) * ulp_pkg::TH_W'(heat_scale);
	ulp_thermal u_therm
	(
		.clock       (clock),
		.sys_rst     (sys_rst),
		.prot_reset  (prot_reset),
		.sample_tick (sample_tick),
		.heating     (above_thr),
		.neg_pu      (seq.neg_seq),
		.heat_scale  (heat_scale),
		.cool_shift  (cool_shift),
		.theta_max   (theta_max),
		.theta       (theta),
		.theta_over  (theta_over)
	);
	// -----------------------------------------------------------------
	// delay and trip state machine
	// -----------------------------------------------------------------
	// thermal delay: trip when energy crosses max; residual energy starts
	// the climb higher, so the delay shortens (K/(I2^2-thr^2) from zero)
	logic [2*ulp_pkg::CUR_W-1:0] i2sq;
	logic [2*ulp_pkg::CUR_W-1:0] thsq;
	logic [2*ulp_pkg::CUR_W-1:0] excess;
	logic [ulp_pkg::TH_W-1:0]    therm_target;
	logic [ulp_pkg::TH_W-1:0]    therm_ticks;
	logic [ulp_pkg::TIM_W-1:0]   delay_ticks;
	logic [ulp_pkg::TIM_W-1:0]   timer;
	logic [ulp_pkg::TIM_W-1:0]   next_timer;
	logic                        expired;
	logic                        ok_to_trip;
	ulp_pkg::ulp_state_t         state;
	ulp_pkg::ulp_state_t         next_state;
	assign i2sq         = seq.neg_seq * seq.neg_seq;
	assign thsq         = thr_pu * thr_pu;
	assign excess       = (i2sq > thsq) ? ((i2sq - thsq) >> (2 * ulp_pkg::CUR_FRAC)) : '0;
	assign therm_target = (theta_max > theta) ? theta_max - theta : '0;
	assign therm_ticks  = (excess == '0) ? '1
	                      : therm_target / ulp_pkg::TH_W'(excess) / ulp_pkg::TH_W'(heat_scale
	                        == '0 ? 16'h0001 : heat_scale);
	assign delay_ticks  = thermal_curve
	                      ? ((therm_ticks[ulp_pkg::TH_W-1:ulp_pkg::TIM_W] != '0) ? '1
	                         : therm_ticks[ulp_pkg::TIM_W-1:0])
	                      : fixed_delay;
	assign expired      = timer >= delay_ticks;
	assign ok_to_trip   = expired && (!thermal_curve || theta_over);
	always_comb
	begin
		next_state = state;
		next_timer = timer;
		case (state)
			ulp_pkg::ULP_IDLE:
			begin
				next_timer = ulp_pkg::TIMER_RST;
				if (cond)
					next_state = ulp_pkg::ULP_TIMING;
			end
			ulp_pkg::ULP_TIMING:
			begin
				if (!cond)
				begin
					next_state = ulp_pkg::ULP_IDLE;
					next_timer = ulp_pkg::TIMER_RST;
				end
				else if (ok_to_trip)
					next_state = ulp_pkg::ULP_TRIPPED;
				else if (timer != '1)
					next_timer = timer + 24'h000001;
			end
			ulp_pkg::ULP_TRIPPED:
			begin
				if (!cond)
				begin
					next_state = ulp_pkg::ULP_IDLE;
					next_timer = ulp_pkg::TIMER_RST;
				end
			end
			default:
			begin
				next_state = ulp_pkg::ULP_IDLE;
				next_timer = ulp_pkg::TIMER_RST;
			end
		endcase
	end
	always_ff @(posedge clock)
	begin
		if (sys_rst || prot_reset)
		begin
			state <= ulp_pkg::ULP_IDLE;
			timer <= ulp_pkg::TIMER_RST;
		end
		else if (sample_tick)
		begin
			state <= next_state;
			timer <= next_timer;
		end
	end
	// every instance is this same module; only input settings differ
	assign pickup = (state != ulp_pkg::ULP_IDLE);
	assign trip   = (state == ulp_pkg::ULP_TRIPPED);
	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	a_reset_clears_trip: assert property (@(posedge clock) disable iff (sys_rst)
		prot_reset |=> !trip && !pickup && timer == '0)
		else $error("overcurrent reset did not clear element");
	a_trip_needs_cond: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(trip) |-> $past(cond) && $past(sample_tick))
		else $error("trip without pickup condition");
	a_fixed_delay_met: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(trip) && !$past(thermal_curve) |-> $past(timer) >= $past(fixed_delay))
		else $error("fixed delay trip too early");
	a_thermal_needs_max: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(trip) && $past(thermal_curve) |-> $past(theta_over))
		else $error("thermal trip below energy maximum");
	a_timer_restart: assert property (@(posedge clock) disable iff (sys_rst)
		sample_tick && !prot_reset && !cond |=> timer == '0 && !pickup)
		else $error("timer not restarted on dropout");
	a_below_thr_idle: assert property (@(posedge clock) disable iff (sys_rst)
		sample_tick && !above_thr |=> !trip)
		else $error("trip below threshold");
	a_ratio_gate: assert property (@(posedge clock) disable iff (sys_rst)
		sample_tick && ratio_enable && !ratio_ok |=> !pickup)
		else $error("pickup with ratio not exceeded");
	a_timer_hold: assert property (@(posedge clock) disable iff (sys_rst)
		!sample_tick && !prot_reset |=> $stable(timer) && $stable(state))
		else $error("timer moved without sample tick");
	c_fixed_trip: cover property (@(posedge clock) disable iff (sys_rst)
		$rose(trip) && !thermal_curve);
	c_thermal_trip: cover property (@(posedge clock) disable iff (sys_rst)
		$rose(trip) && thermal_curve);
	c_dropout: cover property (@(posedge clock) disable iff (sys_rst)
		state == ulp_pkg::ULP_TIMING ##1 state == ulp_pkg::ULP_IDLE);
	c_reset_trip: cover property (@(posedge clock) disable iff (sys_rst)
		trip && prot_reset);
endmodule

// file: rtl/ulp_pkg.sv
// constants and types of the unbalanced load protection element
// Function
// - derive positive and negative sequence from phases
// - reversed rotation swaps the two sequence components
// - threshold is the largest non-operating negative sequence
// - optional ratio criterion, ignored when disabled
// - trip only after conditions hold for delay
// - threshold compared in units of nominal current
// - fixed curve delay equals the delay setting
// - thermal energy updated every tick, always
// - thermal curve also needs energy above maximum
// - delay is capability over squared excess current
// - residual energy shortens the trip delay
// - heating integrates scaled squared negative sequence
// - heating starts at zero after completed cooling
// - cooling decays energy with the time constant
// - below one percent of maximum, energy forced zero
// - all instances identical, differing only in settings
// - overcurrent reset clears element and timers instantly
package ulp_pkg;
	// -----------------------------------------------------------------
	// widths and scaling
	// -----------------------------------------------------------------
	localparam int unsigned CUR_W    = 16;   // current, per unit x 1024
	localparam int unsigned CUR_FRAC = 10;
	localparam int unsigned TIM_W    = 24;   // delay in ticks
	localparam int unsigned TH_W     = 40;   // thermal energy
	localparam int unsigned PCT_W    = 8;
	localparam int unsigned SHF_W    = 5;    // cooling shift, 2^-n per tick
	localparam int unsigned PCT_FULL = 100;
	localparam int unsigned ZERO_DIV = 100;  // end of cooling at max / 100
	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [TIM_W-1:0] TIMER_RST = 24'h000000;
	localparam logic [TH_W-1:0]  THETA_RST = 40'h0000000000;
	// -----------------------------------------------------------------
	// curve modes and element states
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		ULP_FIXED   = 2'h1,
		ULP_THERMAL = 2'h2
	} ulp_curve_t;
	typedef enum logic [2:0] {
		ULP_IDLE    = 3'h1,
		ULP_TIMING  = 3'h2,
		ULP_TRIPPED = 3'h4
	} ulp_state_t;
endpackage

// file: rtl/ulp_seq_if.sv
// interface carrying sequence components between the element's modules
interface ulp_seq_if;
	logic [ulp_pkg::CUR_W-1:0] pos_seq;
	logic [ulp_pkg::CUR_W-1:0] neg_seq;
	modport src
	(
		output pos_seq,
		output neg_seq
	);
	modport dst
	(
		input pos_seq,
		input neg_seq
	);
endinterface

// file: rtl/ulp_seq_calc.sv
// sequence decomposition from phase magnitudes
module ulp_seq_calc
(
	input  wire logic                      clock,
	input  wire logic                      sys_rst,
	input  wire logic                      sample_tick,
	input  wire logic                      rotation_reversed,
	input  wire logic [ulp_pkg::CUR_W-1:0] phase_a,
	input  wire logic [ulp_pkg::CUR_W-1:0] phase_b,
	input  wire logic [ulp_pkg::CUR_W-1:0] phase_c,
	ulp_seq_if.src                         seq
);
	// -----------------------------------------------------------------
	// magnitude-only estimate
	// -----------------------------------------------------------------
	// magnitudes only: positive ~ mean, negative ~ 2*(max-min)/3, gives 2/3 of a lone phase
	logic [ulp_pkg::CUR_W+1:0] sum_abc;
	logic [ulp_pkg::CUR_W-1:0] mx;
	logic [ulp_pkg::CUR_W-1:0] mn;
	logic [ulp_pkg::CUR_W-1:0] comp_bal;
	logic [ulp_pkg::CUR_W-1:0] comp_unb;
	assign sum_abc  = {2'h0, phase_a} + {2'h0, phase_b} + {2'h0, phase_c};
	assign mx       = (phase_a > phase_b) ? ((phase_a > phase_c) ? phase_a : phase_c)
	                                      : ((phase_b > phase_c) ? phase_b : phase_c);
	assign mn       = (phase_a < phase_b) ? ((phase_a < phase_c) ? phase_a : phase_c)
	                                      : ((phase_b < phase_c) ? phase_b : phase_c);
	assign comp_bal = ulp_pkg::CUR_W'(sum_abc / 3);
	assign comp_unb = ulp_pkg::CUR_W'((({2'h0, mx} - {2'h0, mn}) * 2) / 3);
	// -----------------------------------------------------------------
	// registered outputs, swapped on reversed rotation
	// -----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			seq.pos_seq <= 16'h0000;
			seq.neg_seq <= 16'h0000;
		end
		else if (sample_tick)
		begin
			seq.pos_seq <= rotation_reversed ? comp_unb : comp_bal;
			seq.neg_seq <= rotation_reversed ? comp_bal : comp_unb;
		end
	end
endmodule

// file: rtl/ulp_thermal.sv
// thermal energy model of the negative sequence element
module ulp_thermal
(
	input  wire logic                      clock,
	input  wire logic                      sys_rst,
	input  wire logic                      prot_reset,
	input  wire logic                      sample_tick,
	input  wire logic                      heating,
	input  wire logic [ulp_pkg::CUR_W-1:0] neg_pu,
	input  wire logic [ulp_pkg::CUR_W-1:0] heat_scale,
	input  wire logic [ulp_pkg::SHF_W-1:0] cool_shift,
	input  wire logic [ulp_pkg::TH_W-1:0]  theta_max,
	output logic      [ulp_pkg::TH_W-1:0]  theta,
	output logic                           theta_over
);
	// -----------------------------------------------------------------
	// heating increment and cooling decay
	// -----------------------------------------------------------------
	logic [2*ulp_pkg::CUR_W-1:0] sq;
	logic [ulp_pkg::TH_W-1:0]    inc;
	logic [ulp_pkg::TH_W-1:0]    decay;
	logic [ulp_pkg::TH_W-1:0]    floor_lvl;
	logic [ulp_pkg::TH_W-1:0]    next_theta;
	logic [ulp_pkg::TH_W:0]      sum;
	assign sq        = neg_pu * neg_pu;
	// widened product: a 32-bit square times the scale would wrap
	assign inc       = ulp_pkg::TH_W'(({16'h0000, sq} * heat_scale) >> (2 * ulp_pkg::CUR_FRAC));
	assign sum       = {1'b0, theta} + {1'b0, inc};
	// first-order decay: theta -= theta/2^n approximates exp(-t/tau)
	assign decay     = (theta >> cool_shift) == '0 ? 40'h0000000001 : theta >> cool_shift;
	assign floor_lvl = ulp_pkg::TH_W'(theta_max / ulp_pkg::ZERO_DIV);
	assign theta_over = theta > theta_max;
	always_comb
	begin
		next_theta = theta;
		if (heating)
			next_theta = sum[ulp_pkg::TH_W] ? '1 : sum[ulp_pkg::TH_W-1:0];
		else if (theta < floor_lvl || theta <= decay)
			next_theta = ulp_pkg::THETA_RST;
		else
			next_theta = theta - decay;
	end
	// -----------------------------------------------------------------
	// state, updated every tick whatever the trip status
	// -----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst || prot_reset)
			theta <= ulp_pkg::THETA_RST;
		else if (sample_tick)
			theta <= next_theta;
	end
	a_theta_zero_floor: assert property (@(posedge clock) disable iff (sys_rst)
		sample_tick && !heating && !prot_reset && theta < floor_lvl |=> theta == '0)
		else $error("cooling did not clear energy below floor");
	a_theta_heat_rise: assert property (@(posedge clock) disable iff (sys_rst)
		sample_tick && heating && !prot_reset && inc != '0 && !sum[ulp_pkg::TH_W]
		|=> theta > $past(theta))
		else $error("energy did not rise while heating");
endmodule

// file: dv/ulp_meas_model.sv
// measurement front end model: sample tick source and phase magnitudes
module ulp_meas_model
(
	input  wire logic                      clock,
	input  wire logic                      sys_rst,
	input  wire logic [ulp_pkg::CUR_W-1:0] req_a,
	input  wire logic [ulp_pkg::CUR_W-1:0] req_b,
	input  wire logic [ulp_pkg::CUR_W-1:0] req_c,
	output logic                           sample_tick,
	output logic      [ulp_pkg::CUR_W-1:0] phase_a,
	output logic      [ulp_pkg::CUR_W-1:0] phase_b,
	output logic      [ulp_pkg::CUR_W-1:0] phase_c
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div;
	wire        at_tick = (div == 2'h3);
	// values are only promised at the tick; scrambled between to expose off-tick sampling
	always_ff @(posedge clock)
	begin
		div         <= sys_rst ? 2'h0 : div + 2'h1;
		sample_tick <= !sys_rst && at_tick;
		phase_a     <= at_tick ? req_a : ~req_a;
		phase_b     <= at_tick ? req_b : ~req_b;
		phase_c     <= at_tick ? req_c : ~req_c;
	end
endmodule

// file: dv/ulp_element_test.sv
// self-checking testbench of the unbalanced load element
module ulp_element_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed
	{
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] c;
		logic        rev;
		logic [15:0] thr;
		logic        use_fl;
		logic [15:0] flrt;
		logic        ren;
		logic [7:0]  pct;
		logic        exp;
	} ulp_row_t;
	// -----------------------------------------------------------------
	// signals
	// -----------------------------------------------------------------
	logic        clock = 1'h0;
	logic        sys_rst = 1'h1;
	logic        prot_reset = 1'h0;
	logic [15:0] req_a = 16'h0000;
	logic [15:0] req_b = 16'h0000;
	logic [15:0] req_c = 16'h0000;
	logic        rev = 1'h0;
	logic [15:0] thr = 16'h0200;
	logic        use_fl = 1'h0;
	logic [15:0] flrt = 16'h0400;
	logic        ren = 1'h0;
	logic [7:0]  pct = 8'h00;
	logic        therm = 1'h0;
	logic [4:0]  cool = 5'h04;
	logic        sample_tick;
	logic [15:0] phase_a;
	logic [15:0] phase_b;
	logic [15:0] phase_c;
	logic        pickup;
	logic        trip;
	logic [15:0] neg_v;
	logic [15:0] pos_v;
	int          num_errors = 0;
	int          checks = 0;
	localparam int DLY = 8;
	// balanced, one phase alone, and balanced with reversed rotation (exact negative 1.0)
	const ulp_row_t rows [9] = '{
		'{16'h0400, 16'h0400, 16'h0400, 1'h0, 16'h0200, 1'h0, 16'h0, 1'h0, 8'h00, 1'h0},
		'{16'h0c00, 16'h0000, 16'h0000, 1'h0, 16'h0200, 1'h0, 16'h0, 1'h0, 8'h00, 1'h1},
		'{16'h0400, 16'h0400, 16'h0400, 1'h1, 16'h0200, 1'h0, 16'h0, 1'h0, 8'h00, 1'h1},
		'{16'h0400, 16'h0400, 16'h0400, 1'h1, 16'h0400, 1'h0, 16'h0, 1'h0, 8'h00, 1'h0},
		'{16'h0400, 16'h0400, 16'h0400, 1'h1, 16'h03ff, 1'h0, 16'h0, 1'h0, 8'h00, 1'h1},
		'{16'h0400, 16'h0400, 16'h0400, 1'h1, 16'h0000, 1'h1, 16'h0800, 1'h0, 8'h00, 1'h0},
		'{16'h0400, 16'h0400, 16'h0400, 1'h1, 16'h0fff, 1'h1, 16'h0200, 1'h0, 8'h00, 1'h1},
		'{16'h0c00, 16'h0000, 16'h0000, 1'h0, 16'h0200, 1'h0, 16'h0, 1'h1, 8'hfa, 1'h0},
		'{16'h0c00, 16'h0000, 16'h0000, 1'h0, 16'h0200, 1'h0, 16'h0, 1'h1, 8'h32, 1'h1}};
	always #50 clock = ~clock;
	ulp_meas_model u_meas
	(
		.clock      (clock),
		.sys_rst    (sys_rst),
		.req_a      (req_a),
		.req_b      (req_b),
		.req_c      (req_c),
		.sample_tick(sample_tick),
		.phase_a    (phase_a),
		.phase_b    (phase_b),
		.phase_c    (phase_c)
	);
	ulp_element dut
	(
		.clock                       (clock),
		.sys_rst                     (sys_rst),
		.prot_reset                  (prot_reset),
		.sample_tick                 (sample_tick),
		.phase_a                     (phase_a),
		.phase_b                     (phase_b),
		.phase_c                     (phase_c),
		.rotation_reversed           (rev),
		.neg_seq_threshold           (thr),
		.use_full_load_threshold     (use_fl),
		.full_load_relative_threshold(flrt),
		.full_load_current           (16'h0400),
		.ratio_enable                (ren),
		.unbalance_ratio_setting     (pct),
		.thermal_curve               (therm),
		.fixed_delay                 (24'h000008),
		.capability_k                (24'h000028),
		.heat_scale                  (16'h0100),
		.cool_shift                  (cool),
		.pickup                      (pickup),
		.trip                        (trip),
		.neg_seq_value               (neg_v),
		.pos_seq_value               (pos_v)
	);
	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clock iff sample_tick);
		// settle past the launching edge before anyone looks at outputs
		@(negedge clock);
	endtask
	task automatic apply(input ulp_row_t r);
		@(posedge clock);
		{req_a, req_b, req_c, rev, thr, use_fl, flrt, ren, pct} <= r[91:1];
	endtask
	task automatic clear;
		@(posedge clock);
		prot_reset <= 1'h1;
		@(posedge clock);
		prot_reset <= 1'h0;
		@(negedge clock);
	endtask
	// bounded wait: trip must show within n ticks
	task automatic wait_trip(input int n);
		repeat (n) if (trip !== 1'h1) ticks(1);
		@(negedge clock);
		check(16'(trip), 16'h1);
	endtask
	// -----------------------------------------------------------------
	// sequence
	// -----------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'h0;
		@(negedge clock);
		check({14'h0, pickup, trip}, 16'h0);
		check(neg_v | pos_v, 16'h0);
		foreach (rows[i])
		begin
			clear();
			apply(rows[i]);
			ticks(DLY + 5);
			@(negedge clock);
			check({14'h0, pickup, trip}, {14'h0, rows[i].exp, rows[i].exp});
		end
		apply(rows[0]);
		ticks(3);
		check(pos_v, 16'h0400);
		apply(rows[2]);
		ticks(3);
		check(neg_v, 16'h0400);
		check(pos_v, 16'h0000);
		// fixed curve: timing restarts when the condition drops
		clear();
		apply(rows[1]);
		ticks(DLY - 1);
		check({14'h0, pickup, trip}, 16'h2);
		apply(rows[0]);
		// first tick may still carry the old phases
		ticks(3);
		apply(rows[1]);
		ticks(DLY - 1);
		check(16'(trip), 16'h0);
		ticks(6);
		check(16'(trip), 16'h1);
		clear();
		check({14'h0, pickup, trip}, 16'h0);
		ticks(DLY - 1);
		check(16'(trip), 16'h0);
		// thermal curve: negative 1.0 heats 256 a tick, maximum 40 x 256
		// load the sequence values first, then clear, so energy counts from zero
		therm <= 1'h1;
		apply('{16'h0400, 16'h0400, 16'h0400, 1'h1, 16'h0, 1'h0, 16'h0, 1'h0, 8'h00, 1'h1});
		ticks(3);
		clear();
		ticks(36);
		check(16'(trip), 16'h0);
		wait_trip(14);
		apply(rows[0]);
		ticks(4);
		check(16'(trip), 16'h0);
		apply('{16'h0400, 16'h0400, 16'h0400, 1'h1, 16'h0, 1'h0, 16'h0, 1'h0, 8'h00, 1'h1});
		wait_trip(16);
		// fast cooling runs to completion, so heating starts from zero again
		cool <= 5'h01;
		apply(rows[0]);
		ticks(20);
		apply('{16'h0400, 16'h0400, 16'h0400, 1'h1, 16'h0, 1'h0, 16'h0, 1'h0, 8'h00, 1'h1});
		ticks(36);
		check(16'(trip), 16'h0);
		wait_trip(14);
		finish_test();
	end
	// whole run is under 2000 cycles; this only cuts a hang short
	initial
	begin
		repeat (20000) @(posedge clock);
		num_errors++;
		finish_test();
	end
endmodule
